// ---- src/hifl_pkg.sv ----
// Package for the host interrupt mask and FIFO level block.
// Assumes a single 250 MHz core clock and byte addressed register offsets.
package hifl_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int LVL_W = 8;
    localparam logic [ADDR_W-1:0] IRQ_SOURCE_MASK_OFS = 8'h5C;
    localparam logic [ADDR_W-1:0] FIFO_THRESHOLD_CONFIG_OFS = 8'h68;

    // ==========================================================
    // Enable and pending bit positions
    // ==========================================================
    localparam int SOFT_IRQ_BIT = 31;
    localparam int DEVICE_READY_BIT = 30;
    localparam int TIMESTAMP_EVENT_BIT = 29;
    localparam int SWITCH_EVENT_BIT = 28;
    localparam int SECOND_PHY_EVENT_BIT = 27;
    localparam int FIRST_PHY_EVENT_BIT = 26;
    localparam int TRANSMIT_HALTED_BIT = 25;
    localparam int RECEIVE_HALTED_BIT = 24;
    localparam int DROP_COUNTER_HALF_BIT = 23;
    localparam int TRANSMIT_COMPLETION_BIT = 21;
    localparam int RX_DMA_COUNT_BIT = 20;
    localparam int GENERAL_TIMER_BIT = 19;
    localparam int POWER_EVENT_BIT = 17;
    localparam int TX_STATUS_OVERFLOW_BIT = 16;
    localparam int RECEIVE_WATCHDOG_BIT = 15;
    localparam int RECEIVER_FAULT_BIT = 14;
    localparam int TRANSMITTER_FAULT_BIT = 13;
    localparam int GPIO_EVENT_BIT = 12;
    localparam int TX_DATA_OVERRUN_BIT = 10;
    localparam int TX_SPACE_AVAILABLE_BIT = 9;
    localparam int TX_STATUS_FULL_BIT = 8;
    localparam int TX_STATUS_LEVEL_BIT = 7;
    localparam int RX_FRAME_DROPPED_BIT = 6;
    localparam int RX_STATUS_FULL_BIT = 4;
    localparam int RX_STATUS_LEVEL_BIT = 3;

    // Bits 22, 18 and 2:0 are read-only zero; 11 and 5 are stored
    localparam logic [DATA_W-1:0] EN_WRITE_MASK = 32'hFFBB_FFF8;
    // Sources whose events arrive ready-made from neighbouring logic
    localparam logic [DATA_W-1:0] EXT_SOURCE_MASK = 32'h7FBB_F150;
    localparam logic [DATA_W-1:0] EN_RESET = 32'h0000_0000;

    // ==========================================================
    // Threshold register fields
    // ==========================================================
    localparam int TX_AVAIL_LVL_LSB = 24;
    localparam int TX_STS_LVL_LSB = 16;
    localparam int RX_STS_LVL_LSB = 0;
    localparam logic [DATA_W-1:0] LVL_RESET = 32'h4800_0000;

    // ==========================================================
    // Carriers
    // ==========================================================
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } hifl_csr_req_t;

    typedef struct packed {
        logic rvalid;
        logic [DATA_W-1:0] rdata;
    } hifl_csr_rsp_t;

    typedef struct packed {
        logic [LVL_W-1:0] tx_free_blocks;
        logic [LVL_W-1:0] tx_status_used;
        logic [LVL_W-1:0] rx_status_used;
        logic tx_write_attempt;
        logic tx_data_full;
    } hifl_fifo_state_t;

endpackage : hifl_pkg

// ---- src/hifl_flag_bank.sv ----
// Sticky pending flags, one per interrupt source.
// Assumes set and clear are single-cycle pulses on the core clock.
`timescale 1ns/10ps
module hifl_flag_bank (
    input wire logic core_clk_i, // Core clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic [hifl_pkg::DATA_W-1:0] set_i, // Flag set pulses
    input wire logic [hifl_pkg::DATA_W-1:0] clr_i, // Flag clear pulses
    output logic [hifl_pkg::DATA_W-1:0] flags_o // Pending flags
);

    typedef struct packed {
        logic [hifl_pkg::DATA_W-1:0] flags;
    } hifl_bank_state_t;

    hifl_bank_state_t st_reg;
    hifl_bank_state_t st_next;

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        st_next = st_reg;
        // Set applied after clear so a coincident event survives
        st_next.flags = (st_reg.flags & ~clr_i) | set_i;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flags_o = st_reg.flags;

endmodule : hifl_flag_bank

// ---- src/hifl_top.sv ----
// Host interrupt enable mask and FIFO level thresholds.
// Assumes source events, FIFO levels and the register port all come from
// logic on core_clk_i, so nothing here is synchronised.
//
// Behaviour
// RL1: An enabled pending source drives the interrupt; a disabled one cannot.
// RL2: Pending flags record events regardless of enable, except software one.
// RL3: Software interrupt enable is bit 31, read/write, resets to zero.
// RL4: Bits 30..26: ready, timestamp, switch, second PHY, first PHY enables.
// RL5: Bit 25 transmit halted, bit 24 receive halted; read/write, reset zero.
// RL6: Bits 23, 21, 20, 19: drop half, tx completion, rx DMA, timer.
// RL7: Bits 17, 16, 15: power event, tx status overflow, receive watchdog.
// RL8: Bits 14, 13, 12: receiver fault, transmitter fault, GPIO event.
// RL9: FIFO enables at bits 10, 9, 8, 7, 6, 4, 3.
// RL10: Software writes zero into enable bits 11 and 5.
// RL11: Threshold bits 31:24 hold tx space level in 64-byte blocks, reset 48h.
// RL12: Tx space flag sets while free blocks exceed that threshold.
// RL13: Bits 23:16 tx status level; flag sets when occupancy exceeds it.
// RL14: Bits 7:0 rx status level; flag sets when occupancy exceeds it.
// RL15: Software writes zero into threshold bits 15:8.
// RL16: Tx overrun flag sets on a write attempt while tx data FIFO is full.
// RL17: Interrupt output follows any flag-and-enable pair one cycle later.
// RL18: Read-only reserved enable bits read zero and ignore writes.
`timescale 1ns/10ps
module hifl_top (
    input wire logic core_clk_i, // Core clock, 250 MHz
    input wire logic resetn_i, // Async reset, active low
    input wire hifl_pkg::hifl_csr_req_t csr_req_i, // Register request
    output hifl_pkg::hifl_csr_rsp_t csr_rsp_o, // Register read answer
    input wire logic [hifl_pkg::DATA_W-1:0] src_event_i, // Source pulses
    input wire logic soft_irq_req_i, // Software interrupt request
    input wire hifl_pkg::hifl_fifo_state_t fifo_i, // FIFO levels
    input wire logic [hifl_pkg::DATA_W-1:0] flag_clear_i, // W1C pulses
    output logic [hifl_pkg::DATA_W-1:0] irq_pending_flags_o, // Flags
    output logic [hifl_pkg::DATA_W-1:0] irq_source_mask_o, // Enables
    output logic host_irq_o // Host interrupt, active high
);

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [hifl_pkg::DATA_W-1:0] irq_source_mask;
        logic [hifl_pkg::DATA_W-1:0] fifo_threshold_config;
        hifl_pkg::hifl_csr_rsp_t rsp;
        logic irq;
    } hifl_top_state_t;

    hifl_top_state_t st_reg;
    hifl_top_state_t st_next;

    logic [hifl_pkg::DATA_W-1:0] flag_set;
    logic [hifl_pkg::DATA_W-1:0] pending;
    logic [hifl_pkg::LVL_W-1:0] tx_avail_lvl;
    logic [hifl_pkg::LVL_W-1:0] tx_sts_lvl;
    logic [hifl_pkg::LVL_W-1:0] rx_sts_lvl;
    logic hit_en;
    logic hit_lvl;

    assign tx_avail_lvl = st_reg.fifo_threshold_config[
        hifl_pkg::TX_AVAIL_LVL_LSB +: hifl_pkg::LVL_W];
    assign tx_sts_lvl = st_reg.fifo_threshold_config[
        hifl_pkg::TX_STS_LVL_LSB +: hifl_pkg::LVL_W];
    assign rx_sts_lvl = st_reg.fifo_threshold_config[
        hifl_pkg::RX_STS_LVL_LSB +: hifl_pkg::LVL_W];

    assign hit_en = (csr_req_i.addr == hifl_pkg::IRQ_SOURCE_MASK_OFS);
    assign hit_lvl = (csr_req_i.addr == hifl_pkg::FIFO_THRESHOLD_CONFIG_OFS);

    // ==========================================================
    // Flag set sources
    // ==========================================================
    always_comb begin
        // Ready, PHY, switch, timer, GPIO etc pass straight through
        flag_set = src_event_i & hifl_pkg::EXT_SOURCE_MASK; // see RL2
        // Software flag is the only one gated by its enable
        flag_set[hifl_pkg::SOFT_IRQ_BIT] = soft_irq_req_i
            & st_reg.irq_source_mask[hifl_pkg::SOFT_IRQ_BIT]; // see RL2
        flag_set[hifl_pkg::TX_DATA_OVERRUN_BIT] =
            fifo_i.tx_write_attempt & fifo_i.tx_data_full; // see RL16
        // Strictly greater: equal to the level does not fire
        flag_set[hifl_pkg::TX_SPACE_AVAILABLE_BIT] =
            (fifo_i.tx_free_blocks > tx_avail_lvl); // see RL12
        flag_set[hifl_pkg::TX_STATUS_LEVEL_BIT] =
            (fifo_i.tx_status_used > tx_sts_lvl); // see RL13
        flag_set[hifl_pkg::RX_STATUS_LEVEL_BIT] =
            (fifo_i.rx_status_used > rx_sts_lvl); // see RL14
    end

    hifl_flag_bank i_hifl_flag_bank (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .set_i(flag_set),
        .clr_i(flag_clear_i),
        .flags_o(pending)
    );

    // ==========================================================
    // Register access and interrupt output
    // ==========================================================
    always_comb begin
        st_next = st_reg;
        st_next.rsp.rvalid = 1'b0;
        st_next.rsp.rdata = '0;
        if (csr_req_i.wr && hit_en) begin
            // Bits 31..3 stored per map; 22, 18, 2:0 dropped
            st_next.irq_source_mask = csr_req_i.wdata
                & hifl_pkg::EN_WRITE_MASK; // see RL3 see RL18
        end
        if (csr_req_i.wr && hit_lvl) begin
            // Bits 15:8 stored as written; software keeps them zero
            st_next.fifo_threshold_config = csr_req_i.wdata; // see RL11
        end
        if (csr_req_i.rd) begin
            st_next.rsp.rvalid = 1'b1;
            if (hit_en) begin
                st_next.rsp.rdata = st_reg.irq_source_mask; // see RL18
            end else if (hit_lvl) begin
                st_next.rsp.rdata = st_reg.fifo_threshold_config;
            end else begin
                // Unmapped offsets answer with zero
                st_next.rsp.rdata = '0;
            end
        end
        // Each enable bit gates the flag of the same position
        st_next.irq = |(pending & st_reg.irq_source_mask); // see RL1 see RL17
    end

    // Enable layout lives in the shared bit constants
    // (see RL4 see RL5 see RL6 see RL7 see RL8 see RL9)
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_reg.irq_source_mask <= hifl_pkg::EN_RESET; // see RL5
            st_reg.fifo_threshold_config <= hifl_pkg::LVL_RESET; // see RL11
            st_reg.rsp <= '0;
            st_reg.irq <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign csr_rsp_o = st_reg.rsp;
    assign irq_pending_flags_o = pending;
    assign irq_source_mask_o = st_reg.irq_source_mask;
    assign host_irq_o = st_reg.irq;

endmodule : hifl_top

// ---- verif/hifl_assertions.sv ----
// Checker on the ports of hifl_top.
// Assumes one core clock domain and an active-low async reset.
`timescale 1ns/10ps
module hifl_assertions (
    input wire logic core_clk_i, // Clock
    input wire logic resetn_i, // Reset
    input wire hifl_pkg::hifl_csr_req_t csr_req_i, // Request
    input wire hifl_pkg::hifl_csr_rsp_t csr_rsp_o, // Answer
    input wire logic [31:0] src_event_i, // Events
    input wire logic soft_irq_req_i, // Soft request
    input wire hifl_pkg::hifl_fifo_state_t fifo_i, // Levels
    input wire logic [31:0] flag_clear_i, // Clears
    input wire logic [31:0] irq_pending_flags_o, // Flags
    input wire logic [31:0] irq_source_mask_o, // Enables
    input wire logic host_irq_o // Interrupt
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);
    AST_MASK_WR: assert property (
        csr_req_i.wr && csr_req_i.addr == 8'h5C |=> irq_source_mask_o ==
        ($past(csr_req_i.wdata) & 32'hFFBB_FFF8)) else $error("bad mask");
    AST_RSVD_ZERO: assert property (
        (irq_source_mask_o & 32'h0044_0007) == 32'h0) else $error("rsvd");
    AST_MASK_READ: assert property (
        csr_req_i.rd && csr_req_i.addr == 8'h5C |=> csr_rsp_o.rvalid &&
        csr_rsp_o.rdata == $past(irq_source_mask_o)) else $error("bad read");
    AST_IRQ_ON: assert property (
        |(irq_pending_flags_o & irq_source_mask_o) |=> host_irq_o)
        else $error("irq missing");
    AST_IRQ_OFF: assert property (
        !(|(irq_pending_flags_o & irq_source_mask_o)) |=> !host_irq_o)
        else $error("irq spurious");
    AST_OVERRUN: assert property (
        fifo_i.tx_write_attempt && fifo_i.tx_data_full
        |=> irq_pending_flags_o[10]) else $error("overrun lost");
    AST_SOFT_GATE: assert property (
        soft_irq_req_i && !irq_source_mask_o[31] && !irq_pending_flags_o[31]
        |=> !irq_pending_flags_o[31]) else $error("soft ungated");
    AST_EVENT_KEPT: assert property (
        src_event_i[13] |=> irq_pending_flags_o[13] ##1
        (irq_pending_flags_o[13] || $past(flag_clear_i[13])))
        else $error("event lost");
endmodule : hifl_assertions
bind hifl_top hifl_assertions i_hifl_assertions (.core_clk_i, .resetn_i,
    .csr_req_i, .csr_rsp_o, .src_event_i, .soft_irq_req_i, .fifo_i,
    .flag_clear_i, .irq_pending_flags_o, .irq_source_mask_o, .host_irq_o);

// ---- verif/hifl_host_model.sv ----
// Host processor model issuing single-word register accesses.
// Assumes it is the only requester; drives at falling edges.
`timescale 1ns/10ps
module hifl_host_model (
    input wire logic core_clk_i, // Clock
    input wire hifl_pkg::hifl_csr_rsp_t csr_rsp_i, // Answer
    output hifl_pkg::hifl_csr_req_t csr_req_o // Request
);
    initial csr_req_o = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge core_clk_i);
        if (a == 8'h5C) d = d & 32'hFFFF_F7DF;
        if (a == 8'h68) d = d & 32'hFFFF_00FF;
        csr_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk_i);
        csr_req_o = '0;
    endtask : wr
    // Missing answer comes back unknown so any compare fails
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge core_clk_i);
        csr_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(negedge core_clk_i);
        csr_req_o = '0;
        d = csr_rsp_i.rvalid ? csr_rsp_i.rdata : 32'hX;
    endtask : rd
endmodule : hifl_host_model

// ---- verif/tb_hifl_top.sv ----
// Self-checking bench for hifl_top through the host model.
// Assumes a 250 MHz clock; inputs change at falling edges.
`timescale 1ns/10ps
module tb_hifl_top;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic soft_irq_req = 1'b0;
    logic host_irq;
    logic [31:0] src_event = '0, flag_clear = '0, flags, mask;
    hifl_pkg::hifl_csr_req_t csr_req;
    hifl_pkg::hifl_csr_rsp_t csr_rsp;
    hifl_pkg::hifl_fifo_state_t fifo = '0;
    int fail_count = 0;
    int compares = 0;
    always #2 core_clk = ~core_clk;
    hifl_host_model i_hifl_host_model (.core_clk_i(core_clk),
        .csr_rsp_i(csr_rsp), .csr_req_o(csr_req));
    hifl_top i_hifl_top (.core_clk_i(core_clk), .resetn_i(resetn),
        .csr_req_i(csr_req), .csr_rsp_o(csr_rsp), .src_event_i(src_event),
        .soft_irq_req_i(soft_irq_req), .fifo_i(fifo),
        .flag_clear_i(flag_clear), .irq_pending_flags_o(flags),
        .irq_source_mask_o(mask), .host_irq_o(host_irq));
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        i_hifl_host_model.rd(a, d);
        chk(d, e);
    endtask : rdchk
    task automatic clear_flags();
        tick(1);
        flag_clear = 32'hFFFF_FFFF;
        tick(1);
        flag_clear = '0;
    endtask : clear_flags
    task automatic soft_pulse();
        tick(1);
        soft_irq_req = 1'b1;
        tick(1);
        soft_irq_req = 1'b0;
        tick(1);
    endtask : soft_pulse
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict
    initial begin
        tick(5000);
        fail_count++;
        print_verdict();
    end
    initial begin
        tick(20);
        resetn = 1'b1;
        rdchk(8'h5C, 32'h0);
        rdchk(8'h68, 32'h4800_0000);
        rdchk(8'h60, 32'h0);
        // Every wired source, all enables off
        for (int i = 0; i < 32; i++) begin
            if ((32'h7FBB_F150 & (32'h1 << i)) != 32'h0) begin
                tick(1);
                src_event = 32'h1 << i;
                tick(1);
                src_event = '0;
                chk(flags, 32'h1 << i);
                tick(1);
                chk({31'h0, host_irq}, 32'h0);
                clear_flags();
            end
        end
        i_hifl_host_model.wr(8'h5C, 32'hFFFF_FFFF);
        rdchk(8'h5C, 32'hFFBB_F7D8);
        soft_pulse();
        chk(flags, 32'h8000_0000);
        chk({31'h0, host_irq}, 32'h1);
        clear_flags();
        tick(1);
        chk({31'h0, host_irq}, 32'h0);
        i_hifl_host_model.wr(8'h5C, 32'h0);
        soft_pulse();
        chk(flags, 32'h0);
        i_hifl_host_model.wr(8'h68, 32'h1020_3330);
        rdchk(8'h68, 32'h1020_0030);
        // Level equal to threshold must not fire, one above must
        for (int k = 0; k < 2; k++) begin
            fifo.tx_free_blocks = 8'h10 + k[7:0];
            fifo.tx_status_used = 8'h20 + k[7:0];
            fifo.rx_status_used = 8'h30 + k[7:0];
            tick(2);
            chk(flags, (k == 1) ? 32'h288 : 32'h0);
        end
        chk({31'h0, host_irq}, 32'h0);
        i_hifl_host_model.wr(8'h5C, 32'h200);
        chk(mask, 32'h0000_0200);
        tick(1);
        chk({31'h0, host_irq}, 32'h1);
        fifo = '0;
        clear_flags();
        for (int j = 0; j < 2; j++) begin
            tick(1);
            fifo.tx_write_attempt = 1'b1;
            fifo.tx_data_full = j[0];
            tick(1);
            fifo = '0;
            chk(flags, (j == 1) ? 32'h400 : 32'h0);
        end
        // Event and clear in one cycle: the event must survive
        tick(1);
        src_event = 32'h0000_1000;
        flag_clear = 32'hFFFF_FFFF;
        tick(1);
        src_event = '0;
        flag_clear = '0;
        chk(flags, 32'h0000_1000);
        print_verdict();
    end
endmodule : tb_hifl_top
